// ===== nvm_prog_port.sv
`timescale 1ns/1ps
// Contract
// - programming only while reset pin low
// - unlock before any program or erase
// - eeprom write overwrites without prior erase
// - chip erase leaves both arrays all ones
// - mosi sampled on rising sck
// - miso shifted on falling sck
// - unlock second byte echoes during third
// - write page commits buffer to page
// - eeprom written one byte per instruction
// - read instructions return selected location
// - reset pin high ends programming mode
// - page under write reads all ones
// - unlock opcode is ac 53 xx xx
// - eeprom byte under write reads ones
module nvm_prog_port #(
  parameter int FLASH_WAIT = nvm_prog_pkg::FLASH_WAIT_CYC,
  parameter int EEPROM_WAIT = nvm_prog_pkg::EEPROM_WAIT_CYC,
  parameter int ERASE_WAIT = nvm_prog_pkg::ERASE_WAIT_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // programming link
  input wire logic prog_rst_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  // status
  output logic prog_mode_o,
  output logic busy_o
);
  import nvm_prog_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link side and crossings

  logic [23:0] hdr;
  logic [7:0] dat;
  logic hdr_tog;
  logic dat_tog;
  logic hdr_tog_s;
  logic dat_tog_s;
  logic hdr_tog_d;
  logic dat_tog_d;
  logic rst_pin_s;
  logic [7:0] rd_data;

  link_shifter u_link (
    .sck_i(sck_i),
    .prog_rst_n_i(prog_rst_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .reply_i(rd_data),
    .hdr_o(hdr),
    .dat_o(dat),
    .hdr_tog_o(hdr_tog),
    .dat_tog_o(dat_tog)
  );

  sync_2ff #(.RESET_VAL(1'b0)) u_sync_hdr (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(hdr_tog),
    .q_o(hdr_tog_s)
  );

  sync_2ff #(.RESET_VAL(1'b0)) u_sync_dat (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(dat_tog),
    .q_o(dat_tog_s)
  );

  // the pin idles high, so its synchroniser starts out high
  sync_2ff #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(prog_rst_n_i),
    .q_o(rst_pin_s)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      hdr_tog_d <= 1'b0;
      dat_tog_d <= 1'b0;
    end else begin
      hdr_tog_d <= hdr_tog_s;
      dat_tog_d <= dat_tog_s;
    end
  end

  // events only inside a session
  // the toggles clear with the pin and pass the same two stages, so the
  // step they take at session end is masked here
  wire session = !rst_pin_s;
  wire hdr_evt = (hdr_tog_s ^ hdr_tog_d) && session;
  wire dat_evt = (dat_tog_s ^ dat_tog_d) && session;

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode

  function automatic logic [FLASH_AW-1:0] flash_index(
    input logic [7:0] b1,
    input logic [7:0] b2,
    input logic [7:0] b3
  );
    flash_index = {b2[1:0], b3, b1[H_BIT]};
  endfunction : flash_index

  wire [7:0] b1 = hdr[B1_LSB+7:B1_LSB];
  wire [7:0] b2 = hdr[B2_LSB+7:B2_LSB];
  wire [7:0] b3 = hdr[7:0];
  wire is_unlock = (b1 == OP_UNLOCK_B1) && (b2 == OP_UNLOCK_B2);
  wire is_erase = (b1 == OP_UNLOCK_B1) && (b2[7:5] == OP_ERASE_B2_TOP);
  wire is_rd_flash = ((b1 & OP_H_MASK) == OP_RD_FLASH);
  wire is_ld_page = ((b1 & OP_H_MASK) == OP_LD_PAGE);
  wire is_wr_page = (b1 == OP_WR_PAGE);
  wire is_rd_eep = (b1 == OP_RD_EEP);
  wire is_wr_eep = (b1 == OP_WR_EEP);
  wire [FLASH_AW-1:0] rd_flash_idx = flash_index(b1, b2, b3);
  wire [PAGE_W-1:0] hdr_page = rd_flash_idx[FLASH_AW-1:WORD_W+1];
  wire [EEP_AW-1:0] hdr_eaddr = b3[EEP_AW-1:0];
  wire [WORD_W:0] ld_idx = {b3[WORD_W-1:0], b1[H_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // session and unlock

  logic unlocked;
  wr_state_type state;
  wr_state_type next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      unlocked <= 1'b0;
      prog_mode_o <= 1'b0;
    end else begin
      prog_mode_o <= session;
      if (!session) begin
        unlocked <= 1'b0;
      end else if (dat_evt && is_unlock) begin
        unlocked <= 1'b1;
      end
    end
  end

  // act on the fourth byte only
  // a write still in flight refuses new program work; reads go on
  wire cmd_ok = dat_evt && unlocked && (state == ST_IDLE);
  wire start_erase = cmd_ok && is_erase;
  wire start_flash = cmd_ok && is_wr_page;
  wire start_eep = cmd_ok && is_wr_eep;
  wire load_ok = cmd_ok && is_ld_page;

  ////////////////////////////////////////////////////////////////////////////
  // self-timed write sequencer

  logic [PAGE_W-1:0] wr_page;
  logic [EEP_AW-1:0] eep_addr;
  logic [7:0] eep_data;
  wire timer_done = (timer == '0);
  wire commit_flash = (state == ST_FLASH) && timer_done;
  wire commit_eep = (state == ST_EEP) && timer_done;

  always_comb begin
    next_state = state;
    next_timer = timer;
    case (state)
      ST_IDLE: begin
        if (start_erase) begin
          next_state = ST_ERASE;
          next_timer = TIMER_W'(ERASE_WAIT - 1);
        end else if (start_flash) begin
          next_state = ST_FLASH;
          next_timer = TIMER_W'(FLASH_WAIT - 1);
        end else if (start_eep) begin
          next_state = ST_EEP;
          next_timer = TIMER_W'(EEPROM_WAIT - 1);
        end
      end
      default: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      timer <= '0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wr_page <= '0;
      eep_addr <= '0;
      eep_data <= ERASED;
    end else begin
      if (start_flash) begin
        wr_page <= hdr_page;
      end
      if (start_eep) begin
        eep_addr <= hdr_eaddr;
        eep_data <= dat;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page buffer and arrays

  localparam int PAGE_BYTES = 2 ** (WORD_W + 1);
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] flash_mem [2 ** FLASH_AW];
  logic [7:0] eep_mem [2 ** EEP_AW];

  // the buffer returns to ones after a commit so stale words never leak
  // into the next page
  generate
    for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_pbuf
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || commit_flash || start_erase) begin
          pbuf[g] <= ERASED;
        end else if (load_ok && (ld_idx == (WORD_W + 1)'(g))) begin
          pbuf[g] <= dat;
        end
      end
    end
  endgenerate

  // arrays model nonvolatile cells, so they carry no reset
  // erase sets every cell to ones
  // commit the whole page at once
  always_ff @(posedge ref_clk_i) begin
    if (start_erase) begin
      for (int i = 0; i < 2 ** FLASH_AW; i++) begin
        flash_mem[i] <= ERASED;
      end
    end else if (commit_flash) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        flash_mem[{wr_page, (WORD_W + 1)'(i)}] <= pbuf[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (start_erase) begin
      for (int i = 0; i < 2 ** EEP_AW; i++) begin
        eep_mem[i] <= ERASED;
      end
    end else if (commit_eep) begin
      eep_mem[eep_addr] <= eep_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read reply

  // page under write polls as ones
  wire flash_hidden = (state == ST_FLASH) && (hdr_page == wr_page);
  // eeprom byte under write polls as ones
  wire eep_hidden = (state == ST_EEP) && (hdr_eaddr == eep_addr);
  wire [7:0] flash_rd = flash_hidden ? ERASED : flash_mem[rd_flash_idx];
  wire [7:0] eep_rd = eep_hidden ? ERASED : eep_mem[hdr_eaddr];
  // reads return the addressed cell
  // other instructions simply echo their third byte in the fourth
  wire [7:0] next_reply = is_rd_flash ? flash_rd :
                          is_rd_eep ? eep_rd : b3;

  // the reply changes only after byte three, so the link sees it stable
  // for the whole fourth byte
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rd_data <= '0;
    end else if (hdr_evt) begin
      rd_data <= next_reply;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  wire [7:0] pbuf0 = pbuf[0];
  wire [7:0] flash_first = flash_mem[{wr_page, 5'h00}];
  wire [7:0] eep_cell = eep_mem[eep_addr];
  wire [7:0] flash_zero = flash_mem[0];
  wire [7:0] eep_zero = eep_mem[0];

  sequence s_flash_start;
    start_flash;
  endsequence

  sequence s_flash_running;
    (state == ST_FLASH) && (timer == TIMER_W'(FLASH_WAIT - 1));
  endsequence

  a_lock_gate: assert property (
    dat_evt && !unlocked && (state == ST_IDLE) |=> state == ST_IDLE)
    else $error("program work started while locked");

  a_unlock_set: assert property (
    dat_evt && is_unlock |=> unlocked)
    else $error("unlock instruction not taken");

  a_session_end: assert property (
    !session |=> !unlocked && !prog_mode_o)
    else $error("session state kept after reset pin release");

  a_erase_ones: assert property (
    start_erase |=> flash_zero == ERASED && eep_zero == ERASED
      && state == ST_ERASE)
    else $error("chip erase did not leave ones");

  a_flash_timer: assert property (
    s_flash_start |=> s_flash_running)
    else $error("flash write did not start its wait");

  a_page_commit: assert property (
    commit_flash |=> flash_first == $past(pbuf0) && state == ST_IDLE)
    else $error("page buffer not committed");

  a_eep_write: assert property (
    commit_eep |=> eep_cell == $past(eep_data) && !busy_o)
    else $error("eeprom byte not written");

  a_flash_poll: assert property (
    hdr_evt && is_rd_flash && flash_hidden |=> rd_data == ERASED)
    else $error("page under write did not read as ones");

  a_eep_poll: assert property (
    hdr_evt && is_rd_eep && eep_hidden |=> rd_data == ERASED)
    else $error("eeprom byte under write did not read as ones");

endmodule : nvm_prog_port

// ===== nvm_prog_pkg.sv
package nvm_prog_pkg;

  // timing of the self-timed writes
  localparam real REF_CLK_MHZ = 100.0;
  localparam real FLASH_WAIT_MS = 4.5;
  localparam real EEPROM_WAIT_MS = 9.0;
  localparam real ERASE_WAIT_MS = 9.0;
  // a device write must end inside the programmer's wait, so round down
  localparam int FLASH_WAIT_CYC = $rtoi(FLASH_WAIT_MS * 1000.0 * REF_CLK_MHZ);
  localparam int EEPROM_WAIT_CYC = $rtoi(EEPROM_WAIT_MS * 1000.0 * REF_CLK_MHZ);
  localparam int ERASE_WAIT_CYC = $rtoi(ERASE_WAIT_MS * 1000.0 * REF_CLK_MHZ);
  localparam int TIMER_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // array geometry
  localparam int PAGE_W = 6;
  localparam int WORD_W = 4;
  localparam int FLASH_AW = PAGE_W + WORD_W + 1;
  localparam int EEP_AW = 7;
  localparam logic [7:0] ERASED = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // instruction bytes and fields
  localparam int B1_LSB = 16;
  localparam int B2_LSB = 8;
  localparam int H_BIT = 3;
  localparam logic [7:0] OP_UNLOCK_B1 = 8'hac;
  localparam logic [7:0] OP_UNLOCK_B2 = 8'h53;
  localparam logic [2:0] OP_ERASE_B2_TOP = 3'h4;
  localparam logic [7:0] OP_H_MASK = 8'hf7;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_PAGE = 8'h40;
  localparam logic [7:0] OP_WR_PAGE = 8'h4c;
  localparam logic [7:0] OP_RD_EEP = 8'ha0;
  localparam logic [7:0] OP_WR_EEP = 8'hc0;

  ////////////////////////////////////////////////////////////////////////////
  // link bit counter
  localparam int BIT_CNT_W = 5;
  localparam logic [4:0] LAST_HDR_BIT = 5'h17;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [4:0] REPLY_BIT = 5'h18;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FLASH = 2'b01,
    ST_EEP = 2'b11,
    ST_ERASE = 2'b10
  } wr_state_type;

endpackage : nvm_prog_pkg

// ===== sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // level in and out
  input wire logic d_i,
  output logic q_o
);

  logic meta;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : sync_2ff

// ===== link_shifter.sv
`timescale 1ns/1ps
module link_shifter (
  // link pins
  input wire logic sck_i,
  input wire logic prog_rst_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // towards the core
  input wire logic [7:0] reply_i,
  output logic [23:0] hdr_o,
  output logic [7:0] dat_o,
  output logic hdr_tog_o,
  output logic dat_tog_o
);
  import nvm_prog_pkg::*;

  logic [BIT_CNT_W-1:0] cnt;
  logic [31:0] rx;
  logic [7:0] tx;
  wire [31:0] next_rx = {rx[30:0], mosi_i};
  wire byte_start = (cnt[2:0] == 3'h0);
  wire [7:0] load_byte = (cnt == REPLY_BIT) ? reply_i : rx[7:0];
  wire [7:0] next_tx = byte_start ? load_byte : {tx[6:0], 1'b0};

  // a high reset pin clears the link at once; sck stands still then
  // sample on rising
  always_ff @(posedge sck_i or posedge prog_rst_n_i) begin
    if (prog_rst_n_i) begin
      cnt <= '0;
      rx <= '0;
      hdr_o <= '0;
      dat_o <= '0;
      hdr_tog_o <= 1'b0;
      dat_tog_o <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
      rx <= next_rx;
      if (cnt == LAST_HDR_BIT) begin
        hdr_o <= next_rx[23:0];
        hdr_tog_o <= ~hdr_tog_o;
      end
      if (cnt == LAST_BIT) begin
        dat_o <= next_rx[7:0];
        dat_tog_o <= ~dat_tog_o;
      end
    end
  end

  // byte two echoes in byte three
  // reply_i is held still by the core well before bit 24 is loaded
  always_ff @(negedge sck_i or posedge prog_rst_n_i) begin
    if (prog_rst_n_i) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  assign miso_o = tx[7];

  a_data_capture: assert property (@(posedge sck_i) disable iff (prog_rst_n_i)
    cnt == LAST_BIT |=> dat_o == {$past(rx[6:0]), $past(mosi_i)})
    else $error("data byte not captured at bit 32");

endmodule : link_shifter

// ===== isp_programmer.sv
`timescale 1ns/1ps
module isp_programmer (
  // link pins
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic rst_n_o
);
  logic [31:0] rx;
  event done;

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // sck low, reset pin pulsed high
    // pulse after time zero so the link's async clear sees a real edge
    sck_o = 1'b0;
    mosi_o = 1'b0;
    rst_n_o = 1'b0;
    #50;
    rst_n_o = 1'b1;
  end

  // reset pin opens and ends a session
  task automatic pin(input logic v);
    rst_n_o <= v;
  endtask : pin

  // sck stands low between frames; it never runs free
  task automatic xfer(input logic [31:0] tx);
    #3;
    for (int i = 31; i >= 0; i--) begin
      // msb first, set well before the rise
      mosi_o = tx[i];
      // each phase three cpu cycles or more
      #30;
      sck_o = 1'b1;
      rx[i] = miso_i;
      #30;
      // leave the core time to fetch the reply
      if (i == 8) begin
        #60;
      end
      sck_o = 1'b0;
    end
    // released data line must not look held
    mosi_o = ~mosi_o;
    ->done;
  endtask : xfer
endmodule : isp_programmer

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import nvm_prog_pkg::*;
  localparam int FW = 400;
  localparam int EW = 600;
  logic ref_clk_i, nrst_i, prog_rst_n_i, sck_i, mosi_i;
  logic miso_o, prog_mode_o, busy_o;
  int failures, checks;
  logic [15:0] notes[$];
  logic [7:0] pg[32];
  logic [7:0] d;
  logic [6:0] a;
  logic [5:0] p;

  // waits scaled down so reads can land inside a write
  nvm_prog_port #(.FLASH_WAIT(FW), .EEPROM_WAIT(EW), .ERASE_WAIT(EW))
    nvm_prog_port_i (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .prog_rst_n_i(prog_rst_n_i),
    .sck_i(sck_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .prog_mode_o(prog_mode_o),
    .busy_o(busy_o)
  );
  isp_programmer isp_programmer_i (
    .miso_i(miso_o),
    .sck_o(sck_i),
    .mosi_o(mosi_i),
    .rst_n_o(prog_rst_n_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // slot three echoes byte two, slot four holds the reply
  task automatic op(input logic [7:0] b1, b2, b3, b4, r);
    notes.push_back({b2, r});
    isp_programmer_i.xfer({b1, b2, b3, b4});
    repeat (10) @(posedge ref_clk_i);
  endtask : op

  task automatic rd_e(input logic [6:0] ad, input logic [7:0] e);
    op(OP_RD_EEP, 8'h00, {1'b0, ad}, 8'h00, e);
  endtask : rd_e

  task automatic wr_e(input logic [6:0] ad, input logic [7:0] v);
    op(OP_WR_EEP, 8'h00, {1'b0, ad}, v, {1'b0, ad});
  endtask : wr_e

  task automatic rd_f(input logic h, input logic [5:0] pn,
                      input logic [3:0] w, input logic [7:0] e);
    op(OP_RD_FLASH | {4'h0, h, 3'h0}, {6'h00, pn[5:4]}, {pn[3:0], w},
       8'h00, e);
  endtask : rd_f

  task automatic ld(input logic h, input logic [3:0] w, input logic [7:0] v);
    op(OP_LD_PAGE | {4'h0, h, 3'h0}, 8'h00, {4'h0, w}, v, {4'h0, w});
  endtask : ld

  task automatic bz(input logic e);
    check(16'(busy_o), 16'(e));
  endtask : bz

  // bounded wait for the write to end; w > 0 also checks its span
  task automatic idle(input int w);
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    check(16'(n < 2000 && (w == 0 || (n >= w - 12 && n <= w - 4))),
          16'h0001);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    forever begin
      @(isp_programmer_i.done);
      if (notes.size() == 0) begin
        failures++;
        $display("[FAIL] %0t reply with no note", $time);
      end else begin
        check(isp_programmer_i.rx[15:0], notes.pop_front());
      end
    end
  end

  initial begin
    #1000000;
    failures++;
    conclude();
  end

  initial begin
    nrst_i = 1'b0;
    void'($urandom(4));
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    check(16'({prog_mode_o, miso_o}), 16'h0000);
    isp_programmer_i.pin(1'b0);
    repeat (10) @(posedge ref_clk_i);
    check(16'(prog_mode_o), 16'h0001);
    op(8'hac, 8'h9f, 8'h00, 8'h00, 8'h00);
    bz(1'b0);
    op(OP_UNLOCK_B1, OP_UNLOCK_B2, 8'h00, 8'h00, 8'h00);
    op(8'hac, 8'h80, 8'h00, 8'h00, 8'h00);
    bz(1'b1);
    idle(EW);
    for (int i = 0; i < 4; i++) begin
      rd_e(7'($urandom), ERASED);
      rd_f(1'($urandom), 6'($urandom), 4'($urandom), ERASED);
    end
    a = 7'($urandom);
    d = 8'($urandom_range(254));
    wr_e(a, d);
    bz(1'b1);
    rd_e(a, ERASED);
    wr_e(a ^ 7'h01, 8'h5a);
    idle(0);
    rd_e(a, d);
    rd_e(a ^ 7'h01, ERASED);
    wr_e(a, ~d);
    idle(EW);
    rd_e(a, ~d);
    p = 6'($urandom);
    for (int w = 0; w < 16; w++) begin
      for (int h = 0; h < 2; h++) begin
        pg[2 * w + h] = 8'($urandom);
        ld(1'(h), 4'(w), pg[2 * w + h]);
      end
    end
    op(OP_WR_PAGE, {6'h00, p[5:4]}, {p[3:0], 4'h0}, 8'h00, {p[3:0], 4'h0});
    bz(1'b1);
    rd_f(1'b1, p, 4'h9, ERASED);
    idle(0);
    for (int w = 0; w < 16; w++) begin
      for (int h = 0; h < 2; h++) begin
        rd_f(1'(h), p, 4'(w), pg[2 * w + h]);
      end
    end
    isp_programmer_i.pin(1'b1);
    repeat (10) @(posedge ref_clk_i);
    check(16'({prog_mode_o, miso_o}), 16'h0000);
    isp_programmer_i.pin(1'b0);
    repeat (10) @(posedge ref_clk_i);
    wr_e(a, 8'h00);
    bz(1'b0);
    rd_e(a, ~d);
    op(OP_UNLOCK_B1, OP_UNLOCK_B2, 8'h00, 8'h00, 8'h00);
    wr_e(a, 8'h00);
    bz(1'b1);
    idle(EW);
    rd_e(a, 8'h00);
    conclude();
  end
endmodule : testbench
